// ---- fieldbus_master_status_leds.sv ----
// status indicators of the fieldbus master, plus host buffer word port
// assumes host strobes are one cycle and synchronous to clk
//
// Operation
// R01 - run indicator lit normally, off once the watchdog expires
// R02 - host sets word 2 bit 0 to request cyclic exchange
// R03 - slave diagnostics stored in words 2140 to 2179 for the host
// R04 - send/receive indicator steady while starting or stopping exchange
// R05 - send/receive flashes while exchanging, off when no exchange
// R06 - word 0 bit 0 reports exchange started or ended
// R07 - token steady in mode 0/E single master, flashing if multi master
// R08 - token off whenever mode is not 0 or E
// R09 - ready lit exactly in mode 0 or E
// R10 - buffer access indicator lit while host reads or writes words
// R11 - parameter set lit in mode 1, off in mode 0 or E
// R12 - parameter set flashes in mode 1 when no parameters stored
// R13 - response error lit on slave exchange fault, off otherwise
// R14 - on request rising edge, fault lit if no slave or address clash
// R15 - all flashing shares one prescaler rate
`timescale 1ns/1ps
`default_nettype none

module fieldbus_master_status_leds
  import led_status_pkg::*;
#(
  parameter int unsigned FLASH_CYC = FLASH_HALF_CYC,
  parameter int unsigned WDOG_LEN  = WDOG_CYC
)(
  // clock and reset
  input  wire  logic        clk,
  input  wire  logic        rst_n,
  // host buffer word port
  input  wire  logic [11:0] addr,
  input  wire  logic [15:0] wdata,
  input  wire  logic        wr_stb,
  input  wire  logic        rd_stb,
  output logic       [15:0] rdata,
  // internal state of the master
  input  wire  logic [3:0]  op_mode,
  input  wire  logic        wdog_kick,
  input  wire  logic        multi_master,
  input  wire  logic        param_stored,
  input  wire  logic        xchg_busy_start,
  input  wire  logic        xchg_active,
  input  wire  logic        slave_fault,
  input  wire  logic        no_active_slave,
  input  wire  logic        addr_clash,
  input  wire  logic        diag_we,
  input  wire  logic [5:0]  diag_idx,
  input  wire  logic [15:0] diag_data,
  // indicators and interrupt
  output logic              run_indicator,
  output logic              send_receive_indicator,
  output logic              token_indicator,
  output logic              module_ready_indicator,
  output logic              host_buffer_access_indicator,
  output logic              parameter_set_indicator,
  output logic              slave_response_error_indicator,
  output logic              fault_indicator,
  output logic              xchg_request,
  output logic              irq
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [31:0]        flash_cnt;
    logic               flash;
    logic [31:0]        wdog_cnt;
    logic               wdog_expired;
    logic               req;
    logic               req_prev;
    logic               fault;
    logic               access;
    logic [EV_BITS-1:0] irq_stat;
    logic [EV_BITS-1:0] irq_en;
    logic [15:0]        rdata;
    logic [7:0]         leds;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic [15:0] trouble_mem [TROUBLE_WORDS];
  logic        mode_run;
  logic        in_trouble;
  logic [5:0]  trouble_idx;
  logic [EV_BITS-1:0] ev;

  assign mode_run    = (op_mode == MODE_RUN0) || (op_mode == MODE_RUNE);
  assign in_trouble  = (addr >= WORD_TROUBLE_LO) && (addr <= WORD_TROUBLE_HI);
  assign trouble_idx = 6'(addr - WORD_TROUBLE_LO);

  // diagnostics area written by the slave side, read by the host [R03]
  always_ff @(posedge clk)
  begin
    if (diag_we && (diag_idx < 6'(TROUBLE_WORDS)))
    begin
      trouble_mem[diag_idx] <= diag_data; // [R03]
    end
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    ev  = '0;
    // one shared prescaler keeps every flash at the same rate [R15]
    if (s_q.flash_cnt >= FLASH_CYC - 1)
    begin
      s_d.flash_cnt = '0;
      s_d.flash     = ~s_q.flash; // [R15]
    end
    else
    begin
      s_d.flash_cnt = s_q.flash_cnt + 32'h0000_0001;
    end
    // watchdog: sticky once expired, only reset brings it back [R01]
    if (wdog_kick)
    begin
      s_d.wdog_cnt = '0;
    end
    else if (!s_q.wdog_expired)
    begin
      if (s_q.wdog_cnt >= WDOG_LEN - 1)
      begin
        s_d.wdog_expired = 1'b1; // [R01]
        ev[EV_WDOG]      = 1'b1;
      end
      else
      begin
        s_d.wdog_cnt = s_q.wdog_cnt + 32'h0000_0001;
      end
    end
    // host writes the exchange request bit [R02]
    if (wr_stb && addr == WORD_XCHG_REQ)
    begin
      s_d.req = wdata[0]; // [R02]
    end
    s_d.req_prev = s_q.req;
    // fault checked on request rising edge, cleared on falling edge [R14]
    if (s_q.req && !s_q.req_prev)
    begin
      s_d.fault = no_active_slave || addr_clash; // [R14]
      ev[EV_FAULT] = no_active_slave || addr_clash;
    end
    else if (!s_q.req)
    begin
      s_d.fault = 1'b0;
    end
    ev[EV_RSPERR] = slave_fault;
    ev[EV_XCHG]   = xchg_active && !s_q.leds[1];
    // access lamp follows host strobes, held one cycle [R10]
    s_d.access = wr_stb || rd_stb; // [R10]
    // read data, one cycle after the strobe
    s_d.rdata = '0;
    if (rd_stb)
    begin
      if (addr == WORD_XCHG_STATUS)
        s_d.rdata = {15'h0000, xchg_active}; // [R06]
      else if (addr == WORD_XCHG_REQ)
        s_d.rdata = {15'h0000, s_q.req};
      else if (in_trouble)
        s_d.rdata = trouble_mem[trouble_idx]; // [R03]
      else if (addr == WORD_IRQ_STATUS)
        s_d.rdata = {12'h000, s_q.irq_stat};
      else if (addr == WORD_IRQ_ENABLE)
        s_d.rdata = {12'h000, s_q.irq_en};
      else if (addr == WORD_LED_STATUS)
        s_d.rdata = {8'h00, s_q.leds};
      else
        s_d.rdata = RESET_WORD;
    end
    // interrupt: clear first, a same-cycle event wins
    if (wr_stb && addr == WORD_IRQ_ENABLE)
      s_d.irq_en = wdata[EV_BITS-1:0];
    if (wr_stb && addr == WORD_IRQ_CLEAR)
      s_d.irq_stat = s_q.irq_stat & ~wdata[EV_BITS-1:0];
    s_d.irq_stat = s_d.irq_stat | ev;
    // indicator bits
    s_d.leds[0] = !s_q.wdog_expired; // [R01]
    if (xchg_busy_start)
      s_d.leds[1] = 1'b1; // [R04]
    else if (xchg_active)
      s_d.leds[1] = s_q.flash; // [R05]
    else
      s_d.leds[1] = 1'b0; // [R05]
    if (mode_run)
      s_d.leds[2] = multi_master ? s_q.flash : 1'b1; // [R07]
    else
      s_d.leds[2] = 1'b0; // [R08]
    s_d.leds[3] = mode_run; // [R09]
    s_d.leds[4] = s_q.access; // [R10]
    if (op_mode == MODE_PARAM)
      s_d.leds[5] = param_stored ? 1'b1 : s_q.flash; // [R11] [R12]
    else
      s_d.leds[5] = 1'b0; // [R11]
    s_d.leds[6] = slave_fault; // [R13]
    s_d.leds[7] = s_q.fault; // [R14]
  end

  // register the whole state
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign rdata                          = s_q.rdata;
  assign run_indicator                  = s_q.leds[0];
  assign send_receive_indicator         = s_q.leds[1];
  assign token_indicator                = s_q.leds[2];
  assign module_ready_indicator         = s_q.leds[3];
  assign host_buffer_access_indicator   = s_q.leds[4];
  assign parameter_set_indicator        = s_q.leds[5];
  assign slave_response_error_indicator = s_q.leds[6];
  assign fault_indicator                = s_q.leds[7];
  assign xchg_request                   = s_q.req;
  assign irq                            = |(s_q.irq_stat & s_q.irq_en);

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  property p_run_off;
    @(posedge clk) disable iff (!rst_n) s_q.wdog_expired |=> !run_indicator;
  endproperty
  a_run_off: assert property (p_run_off) else $error("run lit after watchdog"); // [R01]

  property p_req;
    @(posedge clk) disable iff (!rst_n)
      (wr_stb && addr == WORD_XCHG_REQ) |=> (xchg_request == $past(wdata[0]));
  endproperty
  a_req: assert property (p_req) else $error("request bit not stored"); // [R02]

  property p_sr_steady;
    @(posedge clk) disable iff (!rst_n) xchg_busy_start |=> send_receive_indicator;
  endproperty
  a_sr_steady: assert property (p_sr_steady) else $error("send lamp not steady"); // [R04]

  property p_sr_off;
    @(posedge clk) disable iff (!rst_n)
      (!xchg_busy_start && !xchg_active) |=> !send_receive_indicator;
  endproperty
  a_sr_off: assert property (p_sr_off) else $error("send lamp lit idle"); // [R05]

  property p_status_word;
    @(posedge clk) disable iff (!rst_n)
      (rd_stb && addr == WORD_XCHG_STATUS) |=> (rdata[0] == $past(xchg_active));
  endproperty
  a_status_word: assert property (p_status_word) else $error("status word wrong"); // [R06]

  property p_token_off;
    @(posedge clk) disable iff (!rst_n) !mode_run |=> !token_indicator;
  endproperty
  a_token_off: assert property (p_token_off) else $error("token lit off mode"); // [R08]

  property p_ready;
    @(posedge clk) disable iff (!rst_n) rst_n |=> (module_ready_indicator == $past(mode_run));
  endproperty
  a_ready: assert property (p_ready) else $error("ready lamp wrong"); // [R09]

  property p_access;
    @(posedge clk) disable iff (!rst_n) (wr_stb || rd_stb) |=> ##1 host_buffer_access_indicator;
  endproperty
  a_access: assert property (p_access) else $error("access lamp missing"); // [R10]

  property p_rsp;
    @(posedge clk) disable iff (!rst_n) slave_fault |=> slave_response_error_indicator;
  endproperty
  a_rsp: assert property (p_rsp) else $error("response error not lit"); // [R13]

  property p_fault;
    @(posedge clk) disable iff (!rst_n)
      ($rose(xchg_request) && (no_active_slave || addr_clash)) |=> ##1 fault_indicator;
  endproperty
  a_fault: assert property (p_fault) else $error("fault not lit"); // [R14]

  // the sampled reset term keeps the first edge after release quiet, since the
  // lamps still show their reset values there although the inputs already ask for light
  property p_token_steady;
    @(posedge clk) disable iff (!rst_n)
      (rst_n && mode_run && !multi_master) |=> token_indicator;
  endproperty
  a_token_steady: assert property (p_token_steady) else $error("token not steady"); // [R07]

  property p_token_flash;
    @(posedge clk) disable iff (!rst_n)
      (rst_n && mode_run && multi_master) |=> (token_indicator == $past(s_q.flash));
  endproperty
  a_token_flash: assert property (p_token_flash) else $error("token not flashing"); // [R07]

  property p_param_steady;
    @(posedge clk) disable iff (!rst_n)
      (rst_n && op_mode == MODE_PARAM && param_stored) |=> parameter_set_indicator;
  endproperty
  a_param_steady: assert property (p_param_steady) else $error("param lamp off"); // [R11]

  property p_param_off;
    @(posedge clk) disable iff (!rst_n) mode_run |=> !parameter_set_indicator;
  endproperty
  a_param_off: assert property (p_param_off) else $error("param lamp lit in run"); // [R11]

  property p_param_flash;
    @(posedge clk) disable iff (!rst_n)
      (rst_n && op_mode == MODE_PARAM && !param_stored)
        |=> (parameter_set_indicator == $past(s_q.flash));
  endproperty
  a_param_flash: assert property (p_param_flash) else $error("param not flashing"); // [R12]

  property p_sr_flash;
    @(posedge clk) disable iff (!rst_n)
      (rst_n && !xchg_busy_start && xchg_active)
        |=> (send_receive_indicator == $past(s_q.flash));
  endproperty
  a_sr_flash: assert property (p_sr_flash) else $error("send lamp not flashing"); // [R05]

  property p_rsp_off;
    @(posedge clk) disable iff (!rst_n) !slave_fault |=> !slave_response_error_indicator;
  endproperty
  a_rsp_off: assert property (p_rsp_off) else $error("response error stuck"); // [R13]

  property p_fault_clear;
    @(posedge clk) disable iff (!rst_n) !xchg_request |=> ##1 !fault_indicator;
  endproperty
  a_fault_clear: assert property (p_fault_clear) else $error("fault lamp stuck"); // [R14]

  property p_flash_hold;
    @(posedge clk) disable iff (!rst_n)
      (s_q.flash_cnt != 32'(FLASH_CYC - 1)) |=> $stable(s_q.flash);
  endproperty
  a_flash_hold: assert property (p_flash_hold) else $error("flash off its rate"); // [R15]

  c_flash: cover property (@(posedge clk) disable iff (!rst_n) $rose(s_q.flash));
  c_fault: cover property (@(posedge clk) disable iff (!rst_n) $rose(fault_indicator));
  c_irq:   cover property (@(posedge clk) disable iff (!rst_n) $rose(irq));
  c_expire: cover property (@(posedge clk) disable iff (!rst_n) $rose(s_q.wdog_expired));
  c_xchg:  cover property (@(posedge clk) disable iff (!rst_n) $rose(xchg_request));

endmodule : fieldbus_master_status_leds

`default_nettype wire

// ---- led_status_pkg.sv ----
// package for the fieldbus master status indicator block
// assumes a 10 MHz module clock and a plain strobe register port
`default_nettype none

package led_status_pkg;

  // ------------------------------------------------------------
  // clock and flash timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned FLASH_HALF_MS   = 250;
  localparam int unsigned FLASH_HALF_CYC  = CLK_HZ / 1000 * FLASH_HALF_MS;
  localparam int unsigned WDOG_MS         = 100;
  localparam int unsigned WDOG_CYC        = CLK_HZ / 1000 * WDOG_MS;

  // ------------------------------------------------------------
  // operation modes (switch encoding)
  // ------------------------------------------------------------
  localparam logic [3:0] MODE_RUN0  = 4'h0;
  localparam logic [3:0] MODE_PARAM = 4'h1;
  localparam logic [3:0] MODE_RUNE  = 4'he;

  // ------------------------------------------------------------
  // shared buffer words
  // ------------------------------------------------------------
  localparam logic [11:0] WORD_XCHG_STATUS = 12'h000; // word 0, bit 0
  localparam logic [11:0] WORD_XCHG_REQ    = 12'h002; // word 2, bit 0
  localparam logic [11:0] WORD_TROUBLE_LO  = 12'h85c; // word 2140
  localparam logic [11:0] WORD_TROUBLE_HI  = 12'h883; // word 2179
  localparam logic [11:0] WORD_IRQ_STATUS  = 12'hf00;
  localparam logic [11:0] WORD_IRQ_ENABLE  = 12'hf01;
  localparam logic [11:0] WORD_IRQ_CLEAR   = 12'hf02;
  localparam logic [11:0] WORD_LED_STATUS  = 12'hf03;
  localparam int unsigned TROUBLE_WORDS    = 40;

  // ------------------------------------------------------------
  // event bit positions
  // ------------------------------------------------------------
  localparam int unsigned EV_WDOG    = 0;
  localparam int unsigned EV_FAULT   = 1;
  localparam int unsigned EV_RSPERR  = 2;
  localparam int unsigned EV_XCHG    = 3;
  localparam int unsigned EV_BITS    = 4;

  localparam logic [15:0] RESET_WORD = 16'h0000;

endpackage : led_status_pkg

`default_nettype wire

// ---- slave_side_model.sv ----
// far-side model: the slave stations as the master sees them
// assumes the scenario code changes just after a rising clock edge
`timescale 1ns/1ps
`default_nettype none

module slave_side_model (
  // clock and reset
  input  wire  logic       clk,
  input  wire  logic       rst_n,
  // scenario code from the bench
  input  wire  logic [2:0] cmd,
  // exchange state toward the master
  output logic             xchg_busy_start,
  output logic             xchg_active,
  output logic             slave_fault,
  output logic             no_active_slave,
  output logic             addr_clash
);
  // ----------------------------------------------------------
  // registered levels, so each moves one edge after its code
  // ----------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {xchg_busy_start, xchg_active, slave_fault} <= 3'h0;
      {no_active_slave, addr_clash} <= 2'h0;
    end
    else
    begin
      no_active_slave <= (cmd == 3'h1);
      addr_clash      <= (cmd == 3'h2);
      xchg_busy_start <= (cmd == 3'h3);
      xchg_active     <= (cmd >= 3'h4); // codes 4 to 7 exchange
      slave_fault     <= (cmd == 3'h5); // a slave stops answering
    end
  end
endmodule : slave_side_model
`default_nettype wire

// ---- fieldbus_master_status_leds_bench.sv ----
// bench for the status indicator block, driven through its word port
// assumes short flash and watchdog counts set below
`timescale 1ns/1ps
`default_nettype none

module fieldbus_master_status_leds_bench;
  import led_status_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [15:0] wdata = 16'h0000;
  logic        wr_stb = 1'b0;
  logic        rd_stb = 1'b0;
  logic [15:0] rdata;
  logic [3:0]  op_mode = MODE_RUN0;
  logic        wdog_kick = 1'b0;
  logic        kick_en = 1'b1;
  logic        multi_master = 1'b0;
  logic        param_stored = 1'b1;
  logic        diag_we = 1'b0;
  logic [5:0]  diag_idx = 6'h00;
  logic [15:0] diag_data = 16'h0000;
  logic [2:0]  cmd = 3'h0;
  logic [7:0]  kcnt = 8'h00;
  wire logic [7:0] lamp;
  logic        xreq;
  logic        irq;
  logic [15:0] v;
  wire logic   xchg_busy_start, xchg_active, slave_fault, no_active_slave, addr_clash;
  int          bad_count = 0;
  int          tests_run = 0;

  // ----------------------------------------------------------
  // clock, watchdog kicks every 8 cycles while enabled
  // ----------------------------------------------------------
  initial
  begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk)
  begin
    kcnt <= kcnt + 8'h01;
    wdog_kick <= kick_en && (kcnt[2:0] == 3'h0);
  end

  slave_side_model SLAVES (.clk(clk), .rst_n(rst_n), .cmd(cmd),
    .xchg_busy_start(xchg_busy_start), .xchg_active(xchg_active),
    .slave_fault(slave_fault), .no_active_slave(no_active_slave), .addr_clash(addr_clash));

  fieldbus_master_status_leds #(.FLASH_CYC(4), .WDOG_LEN(50)) DUT (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .op_mode(op_mode), .wdog_kick(wdog_kick),
    .multi_master(multi_master), .param_stored(param_stored),
    .xchg_busy_start(xchg_busy_start), .xchg_active(xchg_active),
    .slave_fault(slave_fault), .no_active_slave(no_active_slave),
    .addr_clash(addr_clash), .diag_we(diag_we), .diag_idx(diag_idx),
    .diag_data(diag_data), .run_indicator(lamp[0]), .send_receive_indicator(lamp[1]),
    .token_indicator(lamp[2]), .module_ready_indicator(lamp[3]),
    .host_buffer_access_indicator(lamp[4]), .parameter_set_indicator(lamp[5]),
    .slave_response_error_indicator(lamp[6]), .fault_indicator(lamp[7]),
    .xchg_request(xreq), .irq(irq));

  // ----------------------------------------------------------
  // access and compare tasks
  // ----------------------------------------------------------
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report

  task automatic cmp16(input logic [15:0] act, input logic [15:0] exp);
    tests_run++;
    if (act !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h want %h", $time, act, exp);
    end
  endtask : cmp16

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    d = rdata;
  endtask : rd

  // sixteen samples: flashing must show both levels, steady only lit
  task automatic flash(input int i, input logic want);
    int n;
    n = 0;
    repeat (16)
    begin
      step(1);
      n += lamp[i];
    end
    cmp16({15'h0000, want ? (n > 4 && n < 12) : (n == 16)}, 16'h0001);
  endtask : flash

  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    step(2);
    cmp16({15'h0, lamp[0]}, 16'h0001);
    cmp16({15'h0, lamp[3]}, 16'h0001);
    cmp16({15'h0, lamp[5]}, 16'h0000);
    cmp16({14'h0, lamp[7:6]}, 16'h0000);
    cmp16({15'h0, lamp[1]}, 16'h0000);
    rd(WORD_LED_STATUS, v);
    cmp16(v, 16'h000d);
    flash(2, 1'b0);
    @(posedge clk);
    multi_master <= 1'b1;
    step(2);
    flash(2, 1'b1);
    @(posedge clk);
    op_mode <= MODE_RUNE;
    step(2);
    cmp16({15'h0, lamp[3]}, 16'h0001);
    flash(2, 1'b1);
    @(posedge clk);
    op_mode <= MODE_PARAM;
    step(2);
    cmp16({14'h0, lamp[3:2]}, 16'h0000);
    flash(5, 1'b0);
    @(posedge clk);
    param_stored <= 1'b0;
    step(2);
    flash(5, 1'b1);
    @(posedge clk);
    op_mode <= MODE_RUN0;
    param_stored <= 1'b1;
    step(2);
    cmp16({15'h0, lamp[5]}, 16'h0000);
    rd(WORD_XCHG_STATUS, v);
    cmp16(v, 16'h0000);
    step(1);
    cmp16({15'h0, lamp[4]}, 16'h0001);
    step(10);
    cmp16({15'h0, lamp[4]}, 16'h0000);
    // request with no slave, then with an address clash
    for (int c = 1; c <= 2; c++)
    begin
      @(posedge clk);
      cmd <= c[2:0];
      step(2);
      wr(WORD_XCHG_REQ, 16'h0001);
      step(2);
      cmp16({14'h0, lamp[7], xreq}, 16'h0003);
      rd(WORD_IRQ_STATUS, v);
      cmp16(v & 16'h0002, 16'h0002);
      rd(WORD_XCHG_REQ, v);
      cmp16(v, 16'h0001);
      wr(WORD_IRQ_CLEAR, 16'h0002);
      wr(WORD_XCHG_REQ, 16'h0000);
      step(2);
      cmp16({15'h0, lamp[7]}, 16'h0000);
    end
    cmp16({15'h0, irq}, 16'h0000);
    wr(WORD_IRQ_ENABLE, 16'h0004);
    rd(WORD_IRQ_ENABLE, v);
    cmp16(v, 16'h0004);
    @(posedge clk);
    cmd <= 3'h3;
    step(3);
    flash(1, 1'b0);
    @(posedge clk);
    cmd <= 3'h4;
    step(3);
    flash(1, 1'b1);
    rd(WORD_XCHG_STATUS, v);
    cmp16(v & 16'h0001, 16'h0001);
    cmp16({14'h0, lamp[6], irq}, 16'h0000);
    @(posedge clk);
    cmd <= 3'h5;
    step(3);
    cmp16({14'h0, lamp[6], irq}, 16'h0003);
    @(posedge clk);
    cmd <= 3'h0;
    step(3);
    cmp16({14'h0, lamp[6], lamp[1]}, 16'h0000);
    wr(WORD_IRQ_CLEAR, 16'h0004);
    step(2);
    cmp16({15'h0, irq}, 16'h0000);
    // trouble area ends, and one index past them
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk);
      diag_we <= 1'b1;
      diag_idx <= (i == 0) ? 6'h00 : ((i == 1) ? 6'h27 : 6'h28);
      diag_data <= 16'ha5c0 + 16'(i);
      @(posedge clk);
      diag_we <= 1'b0;
    end
    rd(WORD_TROUBLE_LO, v);
    cmp16(v, 16'ha5c0);
    rd(WORD_TROUBLE_HI, v);
    cmp16(v, 16'ha5c1);
    rd(12'h100, v);
    cmp16(v, 16'h0000);
    // watchdog starves
    kick_en <= 1'b0;
    for (int t = 0; t < 80 && lamp[0] !== 1'b0; t++) step(1);
    cmp16({15'h0, lamp[0]}, 16'h0000);
    rd(WORD_IRQ_STATUS, v);
    cmp16(v & 16'h0001, 16'h0001);
    final_report;
  end
endmodule : fieldbus_master_status_leds_bench
`default_nettype wire
